/* File: rtl/iau_map.vh */
// Register offsets, field positions, reset values and opcode patterns of the arithmetic unit.
`ifndef IAU_MAP_VH
`define IAU_MAP_VH

// Register byte offsets on the bus.
`define IAU_OFS_INSN   8'h00
`define IAU_OFS_DST    8'h04
`define IAU_OFS_SRC    8'h08
`define IAU_OFS_R0     8'h0c
`define IAU_OFS_MEMN   8'h10
`define IAU_OFS_MEMM   8'h14
`define IAU_OFS_RES    8'h18
`define IAU_OFS_RESM   8'h1c
`define IAU_OFS_FLAGS  8'h20
`define IAU_OFS_ACCHI  8'h24
`define IAU_OFS_ACCLO  8'h28
`define IAU_OFS_STAT   8'h2c

// Field positions in the flag register.
`define IAU_FLG_T      0
`define IAU_FLG_Q      1
`define IAU_FLG_M      2

// Field positions in the status register.
`define IAU_STS_DSTWR  0
`define IAU_STS_SRCWR  1
`define IAU_STS_ILL    2

// Reset values.
`define IAU_RST_WORD   32'h0000_0000
`define IAU_RST_INSN   16'h0009
`define IAU_RST_ACC    64'h0000_0000_0000_0000

// Post-increment steps of the accumulate forms.
`define IAU_STEP_LONG  32'h0000_0004
`define IAU_STEP_HALF  32'h0000_0002

// Opcode patterns, matched with casez.
`define IAU_OP_SUM_RR       16'h3??c
`define IAU_OP_SUM_IMM      16'h7???
`define IAU_OP_SUM_CARRY    16'h3??e
`define IAU_OP_SUM_OVF      16'h3??f
`define IAU_OP_EQ_IMM       16'h88??
`define IAU_OP_EQ_RR        16'h3??0
`define IAU_OP_UHS          16'h3??2
`define IAU_OP_SGE          16'h3??3
`define IAU_OP_UHI          16'h3??6
`define IAU_OP_SGT          16'h3??7
`define IAU_OP_PLUS_ZERO    16'h4?11
`define IAU_OP_POSITIVE     16'h4?15
`define IAU_OP_BYTE_MATCH   16'h2??c
`define IAU_OP_QSTEP        16'h3??4
`define IAU_OP_QSETUP_S     16'h2??7
`define IAU_OP_QSETUP_U     16'h0019
`define IAU_OP_WIDE_S       16'h3??d
`define IAU_OP_WIDE_U       16'h3??5
`define IAU_OP_DEC_TEST     16'h4?10
`define IAU_OP_SWIDEN_B     16'h6??e
`define IAU_OP_SWIDEN_H     16'h6??f
`define IAU_OP_ZWIDEN_B     16'h6??c
`define IAU_OP_ZWIDEN_H     16'h6??d
`define IAU_OP_ACC_LONG     16'h0??f
`define IAU_OP_ACC_HALF     16'h4??f
`define IAU_OP_PROD_LOW     16'h0??7
`define IAU_OP_HPROD_S      16'h2??f
`define IAU_OP_HPROD_U      16'h2??e
`define IAU_OP_NEGATE       16'h6??b
`define IAU_OP_NEG_BORROW   16'h6??a
`define IAU_OP_DIFF         16'h3??8
`define IAU_OP_DIFF_BORROW  16'h3??a
`define IAU_OP_DIFF_UNDER   16'h3??b

`endif

/* File: rtl/iau_core.v */
// Integer arithmetic datapath with an AHB-Lite register port.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "iau_map.vh"

module iau_core
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output reg  [31:0] hrdata,
	output wire        hresp
);

	// Bus address phase capture.
	reg        wr_pend_q;
	reg        rd_pend_q;
	reg  [7:0] addr_q;

	// Software-visible registers and the execute strobe.
	reg [15:0] insn_q;
	reg [31:0] dst_q;
	reg [31:0] src_q;
	reg [31:0] r0_q;
	reg [31:0] memn_q;
	reg [31:0] memm_q;
	reg [31:0] res_q;
	reg [31:0] resm_q;
	reg        t_q;
	reg        q_q;
	reg        m_q;
	reg [63:0] acc_q;
	reg        dstwr_q;
	reg        srcwr_q;
	reg        ill_q;
	reg        go_q;

	// Next values from the execution logic.
	reg [31:0] res_d;
	reg [31:0] resm_d;
	reg        t_d;
	reg        q_d;
	reg        m_d;
	reg [63:0] acc_d;
	reg        dstwr_d;
	reg        srcwr_d;
	reg        ill_d;

	wire        addr_ok;
	wire        wr_hit;
	wire [31:0] imm_sx;
	wire [32:0] sum_rr;
	wire [32:0] sum_cy;
	wire [32:0] dif_rr;
	wire [32:0] dif_bw;
	wire [32:0] neg_bw;
	wire [31:0] sh_n;
	wire        q_msb;
	wire [32:0] div_add;
	wire [32:0] div_sub;
	wire signed [63:0] prod_s;
	wire [63:0]        prod_u;
	wire signed [63:0] mem_prod_l;
	wire signed [31:0] mem_prod_h;
	wire signed [31:0] half_prod_s;
	wire [31:0]        half_prod_u;
	reg  [32:0] div_r;
	reg         div_c;
	reg         q_new;

	// A word written to the instruction register executes on the next edge.
	// The slave stalls that one cycle so a following read sees the result.
	assign hreadyout = ~go_q;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel & htrans[1] & hready;
	assign wr_hit    = wr_pend_q & hreadyout;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end
		else if (hreadyout)
		begin
			wr_pend_q <= addr_ok & hwrite;
			rd_pend_q <= addr_ok & ~hwrite;
			addr_q    <= addr_ok ? haddr[7:0] : addr_q;
		end
	end

	assign imm_sx = {{24{insn_q[7]}}, insn_q[7:0]};

	// Shared adders; widths carry the carry or borrow bit out.
	assign sum_rr = {1'b0, dst_q} + {1'b0, src_q};
	assign sum_cy = {1'b0, dst_q} + {1'b0, src_q} + {32'h0000_0000, t_q};
	assign dif_rr = {1'b0, dst_q} - {1'b0, src_q};
	assign dif_bw = {1'b0, dst_q} - {1'b0, src_q} - {32'h0000_0000, t_q};
	assign neg_bw = 33'h0_0000_0000 - {1'b0, src_q} - {32'h0000_0000, t_q};

	// Division step operands: shift the flag in, add or subtract divisor.
	assign sh_n    = {dst_q[30:0], t_q};
	assign q_msb   = dst_q[31];
	assign div_add = {1'b0, sh_n} + {1'b0, src_q};
	assign div_sub = {1'b0, sh_n} - {1'b0, src_q};

	// Products; operands are widened first, so each product already has the width
	// it is stored in and the low bits of a sign-extended product are the signed result.
	assign prod_s      = {{32{dst_q[31]}}, dst_q} * {{32{src_q[31]}}, src_q};
	assign prod_u      = {32'h0000_0000, dst_q} * {32'h0000_0000, src_q};
	assign mem_prod_l  = {{32{memn_q[31]}}, memn_q} * {{32{memm_q[31]}}, memm_q};
	assign mem_prod_h  = {{16{memn_q[15]}}, memn_q[15:0]} * {{16{memm_q[15]}}, memm_q[15:0]};
	assign half_prod_s = {{16{dst_q[15]}}, dst_q[15:0]} * {{16{src_q[15]}}, src_q[15:0]};
	assign half_prod_u = {16'h0000, dst_q[15:0]} * {16'h0000, src_q[15:0]};

	// add or subtract chosen by old quotient bit versus divisor sign
	always @*
	begin
		if (q_q == m_q)
		begin
			div_r = div_sub;
		end
		else
		begin
			div_r = div_add;
		end
		div_c = div_r[32];
		q_new = q_msb ^ div_c ^ m_q;
	end

	// Instruction decode and execution; defaults hold flags and accumulator, pass the operands to the results and clear status.
	always @*
	begin
		res_d   = dst_q;
		resm_d  = src_q;
		t_d     = t_q;
		q_d     = q_q;
		m_d     = m_q;
		acc_d   = acc_q;
		dstwr_d = 1'b0;
		srcwr_d = 1'b0;
		ill_d   = 1'b0;
		casez (insn_q)
		`IAU_OP_SUM_RR:
		begin
			res_d   = sum_rr[31:0];
			dstwr_d = 1'b1;
		end
		`IAU_OP_SUM_IMM:
		begin
			res_d   = dst_q + imm_sx;
			dstwr_d = 1'b1;
		end
		`IAU_OP_SUM_CARRY:
		begin
			res_d   = sum_cy[31:0];
			t_d     = sum_cy[32];
			dstwr_d = 1'b1;
		end
		`IAU_OP_SUM_OVF:
		begin
			res_d   = sum_rr[31:0];
			t_d     = (dst_q[31] == src_q[31]) && (sum_rr[31] != dst_q[31]);
			dstwr_d = 1'b1;
		end
		`IAU_OP_EQ_IMM:
			t_d = (r0_q == imm_sx);
		`IAU_OP_EQ_RR:
			t_d = (dst_q == src_q);
		`IAU_OP_UHS:
			t_d = (dst_q >= src_q);
		`IAU_OP_SGE:
			t_d = ($signed(dst_q) >= $signed(src_q));
		`IAU_OP_UHI:
			t_d = (dst_q > src_q);
		`IAU_OP_SGT:
			t_d = ($signed(dst_q) > $signed(src_q));
		`IAU_OP_PLUS_ZERO:
			t_d = ~dst_q[31];
		`IAU_OP_POSITIVE:
			t_d = ~dst_q[31] && (dst_q != 32'h0000_0000);
		`IAU_OP_BYTE_MATCH:
			t_d = (dst_q[31:24] == src_q[31:24]) || (dst_q[23:16] == src_q[23:16]) ||
				(dst_q[15:8] == src_q[15:8]) || (dst_q[7:0] == src_q[7:0]);
		`IAU_OP_QSTEP:
		begin
			res_d   = div_r[31:0];
			q_d     = q_new;
			t_d     = (q_new == m_q);
			dstwr_d = 1'b1;
		end
		`IAU_OP_QSETUP_S:
		begin
			q_d = dst_q[31];
			m_d = src_q[31];
			t_d = dst_q[31] ^ src_q[31];
		end
		`IAU_OP_QSETUP_U:
		begin
			q_d = 1'b0;
			m_d = 1'b0;
			t_d = 1'b0;
		end
		`IAU_OP_WIDE_S:
			acc_d = prod_s;
		`IAU_OP_WIDE_U:
			acc_d = prod_u;
		`IAU_OP_DEC_TEST:
		begin
			res_d   = dst_q - 32'h0000_0001;
			t_d     = (dst_q == 32'h0000_0001);
			dstwr_d = 1'b1;
		end
		`IAU_OP_SWIDEN_B:
		begin
			res_d   = {{24{src_q[7]}}, src_q[7:0]};
			dstwr_d = 1'b1;
		end
		`IAU_OP_SWIDEN_H:
		begin
			res_d   = {{16{src_q[15]}}, src_q[15:0]};
			dstwr_d = 1'b1;
		end
		`IAU_OP_ZWIDEN_B:
		begin
			res_d   = {24'h00_0000, src_q[7:0]};
			dstwr_d = 1'b1;
		end
		`IAU_OP_ZWIDEN_H:
		begin
			res_d   = {16'h0000, src_q[15:0]};
			dstwr_d = 1'b1;
		end
		// long accumulate with step of four
		`IAU_OP_ACC_LONG:
		begin
			acc_d   = acc_q + mem_prod_l;
			res_d   = dst_q + `IAU_STEP_LONG;
			resm_d  = src_q + `IAU_STEP_LONG;
			dstwr_d = 1'b1;
			srcwr_d = 1'b1;
		end
		// half accumulate with step of two
		`IAU_OP_ACC_HALF:
		begin
			acc_d   = acc_q + {{32{mem_prod_h[31]}}, mem_prod_h};
			res_d   = dst_q + `IAU_STEP_HALF;
			resm_d  = src_q + `IAU_STEP_HALF;
			dstwr_d = 1'b1;
			srcwr_d = 1'b1;
		end
		`IAU_OP_PROD_LOW:
			acc_d = {acc_q[63:32], prod_u[31:0]};
		`IAU_OP_HPROD_S:
			acc_d = {acc_q[63:32], half_prod_s};
		`IAU_OP_HPROD_U:
			acc_d = {acc_q[63:32], half_prod_u};
		`IAU_OP_NEGATE:
		begin
			res_d   = 32'h0000_0000 - src_q;
			dstwr_d = 1'b1;
		end
		`IAU_OP_NEG_BORROW:
		begin
			res_d   = neg_bw[31:0];
			t_d     = neg_bw[32];
			dstwr_d = 1'b1;
		end
		`IAU_OP_DIFF:
		begin
			res_d   = dif_rr[31:0];
			dstwr_d = 1'b1;
		end
		`IAU_OP_DIFF_BORROW:
		begin
			res_d   = dif_bw[31:0];
			t_d     = dif_bw[32];
			dstwr_d = 1'b1;
		end
		`IAU_OP_DIFF_UNDER:
		begin
			res_d   = dif_rr[31:0];
			t_d     = (dst_q[31] != src_q[31]) && (dif_rr[31] != dst_q[31]);
			dstwr_d = 1'b1;
		end
		default:
			ill_d = 1'b1;
		endcase
	end

	// Operand and instruction registers written by software.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			insn_q <= `IAU_RST_INSN;
			dst_q  <= `IAU_RST_WORD;
			src_q  <= `IAU_RST_WORD;
			r0_q   <= `IAU_RST_WORD;
			memn_q <= `IAU_RST_WORD;
			memm_q <= `IAU_RST_WORD;
			go_q   <= 1'b0;
		end
		else
		begin
			go_q <= wr_hit && (addr_q == `IAU_OFS_INSN);
			if (wr_hit)
			begin
				case (addr_q)
				`IAU_OFS_INSN: insn_q <= hwdata[15:0];
				`IAU_OFS_DST:  dst_q  <= hwdata;
				`IAU_OFS_SRC:  src_q  <= hwdata;
				`IAU_OFS_R0:   r0_q   <= hwdata;
				`IAU_OFS_MEMN: memn_q <= hwdata;
				`IAU_OFS_MEMM: memm_q <= hwdata;
				default:       insn_q <= insn_q;
				endcase
			end
		end
	end

	// Results, flags and accumulator; software writes only land when idle,
	// because the stall keeps any data phase out of the execute cycle.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			res_q   <= `IAU_RST_WORD;
			resm_q  <= `IAU_RST_WORD;
			t_q     <= 1'b0;
			q_q     <= 1'b0;
			m_q     <= 1'b0;
			acc_q   <= `IAU_RST_ACC;
			dstwr_q <= 1'b0;
			srcwr_q <= 1'b0;
			ill_q   <= 1'b0;
		end
		else if (go_q)
		begin
			res_q   <= res_d;
			resm_q  <= resm_d;
			t_q     <= t_d;
			q_q     <= q_d;
			m_q     <= m_d;
			acc_q   <= acc_d;
			dstwr_q <= dstwr_d;
			srcwr_q <= srcwr_d;
			ill_q   <= ill_d;
		end
		else if (wr_hit)
		begin
			case (addr_q)
			`IAU_OFS_FLAGS:
			begin
				t_q <= hwdata[`IAU_FLG_T];
				q_q <= hwdata[`IAU_FLG_Q];
				m_q <= hwdata[`IAU_FLG_M];
			end
			`IAU_OFS_ACCHI: acc_q[63:32] <= hwdata;
			`IAU_OFS_ACCLO: acc_q[31:0]  <= hwdata;
			default:        t_q <= t_q;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero and answer OKAY.
	always @*
	begin
		hrdata = 32'h0000_0000;
		if (rd_pend_q)
		begin
			case (addr_q)
			`IAU_OFS_INSN:  hrdata = {16'h0000, insn_q};
			`IAU_OFS_DST:   hrdata = dst_q;
			`IAU_OFS_SRC:   hrdata = src_q;
			`IAU_OFS_R0:    hrdata = r0_q;
			`IAU_OFS_MEMN:  hrdata = memn_q;
			`IAU_OFS_MEMM:  hrdata = memm_q;
			`IAU_OFS_RES:   hrdata = res_q;
			`IAU_OFS_RESM:  hrdata = resm_q;
			`IAU_OFS_FLAGS: hrdata = {29'h0000_0000, m_q, q_q, t_q};
			`IAU_OFS_ACCHI: hrdata = acc_q[63:32];
			`IAU_OFS_ACCLO: hrdata = acc_q[31:0];
			`IAU_OFS_STAT:  hrdata = {29'h0000_0000, ill_q, srcwr_q, dstwr_q};
			default:        hrdata = 32'h0000_0000;
			endcase
		end
	end

endmodule

/* File: verif/iau_props.sv */
// Bus-side assertion checker for the arithmetic unit.
`timescale 1ns/1ps
module iau_props
(
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire [31:0] hrdata,
	input wire        hresp
);
	reg        dph_q;
	reg        wr_q;
	reg  [7:0] adr_q;
	reg [15:0] ins_q;
	wire       go = hready && dph_q && wr_q && adr_q == 8'h00;
	wire       rdp = hreadyout && dph_q && !wr_q;

	// Follow the data phase; stalled cycles must not advance it.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_q <= 1'b0;
			wr_q  <= 1'b0;
			adr_q <= 8'h00;
			ins_q <= 16'h0009;
		end
		else if (hready)
		begin
			if (go)
				ins_q <= hwdata[15:0];
			dph_q <= hsel && htrans[1];
			wr_q  <= hwrite;
			adr_q <= haddr[7:0];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_one; !hreadyout |=> hreadyout; endproperty
	a_one: assert property (p_one) else $error("stall longer than one cycle");
	property p_go; go |=> !hreadyout; endproperty
	a_go: assert property (p_go) else $error("no stall after instruction write");
	property p_why; !hreadyout |-> $past(go); endproperty
	a_why: assert property (p_why) else $error("stall without instruction write");
	property p_fast; hready && dph_q && wr_q && adr_q != 8'h00 |=> hreadyout; endproperty
	a_fast: assert property (p_fast) else $error("wait state on plain write");
	property p_unmap; rdp && adr_q >= 8'h30 |-> hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_flg; rdp && adr_q == 8'h20 |-> hrdata[31:3] == 29'h0; endproperty
	a_flg: assert property (p_flg) else $error("flag register upper bits set");
	property p_qsu; rdp && adr_q == 8'h2c && ins_q == 16'h0019 |-> hrdata[2:0] == 3'h0;
	endproperty
	a_qsu: assert property (p_qsu) else $error("status after setup not clear");
endmodule

bind iau_core iau_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

/* File: verif/iau_master.sv */
// Bus master model that stands in for the processor and the decoder.
`timescale 1ns/1ps
module iau_master
(
	input  wire         hclk,
	input  wire         hready,
	input  wire  [31:0] hrdata,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	// Idle bus at time zero.
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One single transfer; stale write data is inverted so it never looks valid.
	task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : ~d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the arithmetic unit.
`timescale 1ns/1ps
module tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	wire         hsel;
	wire  [31:0] haddr;
	wire  [1:0]  htrans;
	wire         hwrite;
	wire  [2:0]  hsize;
	wire  [31:0] hwdata;
	wire         hready;
	wire  [31:0] hrdata;
	wire         hresp;
	logic [31:0] v;
	logic [15:0] op;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;

	iau_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp));
	iau_master m (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// Clock of 4 ns period.
	initial
	begin
		forever #2 hclk = ~hclk;
	end

	task end_sim;
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A run takes under a thousand cycles, so this ceiling means a hang.
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_fail++;
			end_sim();
		end
	end

	task w(input [7:0] a, input [31:0] d);
		if (a == 8'h00)
			op = d[15:0];
		m.xfer(1'b1, a, d, v);
	endtask

	task rc(input [7:0] a, input [31:0] e);
		m.xfer(1'b0, a, 32'h0, v);
		n_tests++;
		if (v !== e)
			$display("[FAIL] reg %h after op %h exp %h got %h", a, op, e, v);
		if (v !== e)
			n_fail++;
	endtask

	// Load flag and operands, execute, then check result and flags.
	task run(input [15:0] o, input [31:0] d, s, input t, input [31:0] er, input et);
		w(8'h20, {31'h0, t});
		w(8'h04, d);
		w(8'h08, s);
		w(8'h00, {16'h0, o});
		rc(8'h18, er);
		rc(8'h20, {31'h0, et});
	endtask

	task t_rst;
		rc(8'h20, 32'h0);
		rc(8'h24, 32'h0);
		w(8'h30, 32'hdeadbeef);
		rc(8'h30, 32'h0);
		w(8'h18, 32'h5);
		rc(8'h18, 32'h0);
		w(8'h00, 32'h0009);
		rc(8'h2c, 32'h4);
	endtask

	task t_add;
		run(16'h312c, 32'hffffffff, 32'h2, 1'b1, 32'h1, 1'b1);
		rc(8'h2c, 32'h1);
		run(16'h71ff, 32'h5, 32'h0, 1'b0, 32'h4, 1'b0);
		run(16'h312e, 32'hffffffff, 32'h0, 1'b1, 32'h0, 1'b1);
		run(16'h312e, 32'h1, 32'h2, 1'b0, 32'h3, 1'b0);
		run(16'h312f, 32'h7fffffff, 32'h1, 1'b0, 32'h80000000, 1'b1);
		run(16'h312f, 32'h1, 32'h1, 1'b1, 32'h2, 1'b0);
	endtask

	task t_cmp;
		w(8'h0c, 32'hffffffff);
		run(16'h88ff, 32'h7, 32'h0, 1'b0, 32'h7, 1'b1);
		w(8'h0c, 32'h000000ff);
		run(16'h88ff, 32'h7, 32'h0, 1'b1, 32'h7, 1'b0);
		run(16'h3120, 32'h5, 32'h5, 1'b0, 32'h5, 1'b1);
		run(16'h3120, 32'h5, 32'h4, 1'b1, 32'h5, 1'b0);
		run(16'h3122, 32'hffffffff, 32'h1, 1'b0, 32'hffffffff, 1'b1);
		run(16'h3122, 32'h1, 32'h2, 1'b1, 32'h1, 1'b0);
		run(16'h3123, 32'hffffffff, 32'h1, 1'b1, 32'hffffffff, 1'b0);
		run(16'h3123, 32'h5, 32'h5, 1'b0, 32'h5, 1'b1);
		run(16'h3126, 32'h5, 32'h5, 1'b1, 32'h5, 1'b0);
		run(16'h3126, 32'hffffffff, 32'h1, 1'b0, 32'hffffffff, 1'b1);
		run(16'h3127, 32'h1, 32'hffffffff, 1'b0, 32'h1, 1'b1);
		run(16'h3127, 32'h5, 32'h5, 1'b1, 32'h5, 1'b0);
		run(16'h4111, 32'h0, 32'h0, 1'b0, 32'h0, 1'b1);
		run(16'h4111, 32'h80000000, 32'h0, 1'b1, 32'h80000000, 1'b0);
		run(16'h4115, 32'h0, 32'h0, 1'b1, 32'h0, 1'b0);
		run(16'h4115, 32'h5, 32'h0, 1'b0, 32'h5, 1'b1);
		run(16'h212c, 32'h12345678, 32'haa34bbcc, 1'b0, 32'h12345678, 1'b1);
		run(16'h212c, 32'h12345678, 32'h87654321, 1'b1, 32'h12345678, 1'b0);
	endtask

	task t_div;
		w(8'h20, 32'h0);
		w(8'h04, 32'h80000000);
		w(8'h08, 32'h1);
		w(8'h00, 32'h2127);
		rc(8'h20, 32'h3);
		w(8'h08, 32'hffffffff);
		w(8'h00, 32'h2127);
		rc(8'h20, 32'h6);
		w(8'h00, 32'h0019);
		rc(8'h20, 32'h0);
		rc(8'h2c, 32'h0);
		run(16'h3124, 32'h40000000, 32'h10000000, 1'b0, 32'h70000000, 1'b1);
	endtask

	task t_mul;
		run(16'h312d, 32'hffffffff, 32'h2, 1'b1, 32'hffffffff, 1'b1);
		rc(8'h24, 32'hffffffff);
		rc(8'h28, 32'hfffffffe);
		run(16'h3125, 32'hffffffff, 32'h2, 1'b0, 32'hffffffff, 1'b0);
		rc(8'h24, 32'h1);
		run(16'h0127, 32'h3, 32'h5, 1'b0, 32'h3, 1'b0);
		rc(8'h28, 32'hf);
		run(16'h212f, 32'hffff, 32'h2, 1'b0, 32'hffff, 1'b0);
		rc(8'h28, 32'hfffffffe);
		run(16'h212e, 32'hffff, 32'h2, 1'b0, 32'hffff, 1'b0);
		rc(8'h28, 32'h1fffe);
		rc(8'h24, 32'h1);
	endtask

	task t_acc;
		w(8'h24, 32'h0);
		w(8'h28, 32'ha);
		w(8'h10, 32'h3);
		w(8'h14, 32'hfffffffe);
		run(16'h012f, 32'h100, 32'h200, 1'b1, 32'h104, 1'b1);
		rc(8'h1c, 32'h204);
		rc(8'h2c, 32'h3);
		rc(8'h28, 32'h4);
		w(8'h10, 32'h00030003);
		w(8'h14, 32'hfffefffe);
		run(16'h412f, 32'h100, 32'h200, 1'b0, 32'h102, 1'b0);
		rc(8'h1c, 32'h202);
		rc(8'h24, 32'hffffffff);
		rc(8'h28, 32'hfffffffe);
	endtask

	task t_misc;
		run(16'h4110, 32'h1, 32'h0, 1'b0, 32'h0, 1'b1);
		run(16'h4110, 32'h0, 32'h0, 1'b1, 32'hffffffff, 1'b0);
		run(16'h612e, 32'h0, 32'h80, 1'b0, 32'hffffff80, 1'b0);
		run(16'h612e, 32'h0, 32'h17f, 1'b0, 32'h7f, 1'b0);
		run(16'h612f, 32'h0, 32'h8000, 1'b1, 32'hffff8000, 1'b1);
		run(16'h612c, 32'h0, 32'hffffff80, 1'b0, 32'h80, 1'b0);
		run(16'h612d, 32'h0, 32'hffff8000, 1'b0, 32'h8000, 1'b0);
		run(16'h612b, 32'h9, 32'h1, 1'b1, 32'hffffffff, 1'b1);
		run(16'h612a, 32'h9, 32'h0, 1'b1, 32'hffffffff, 1'b1);
		run(16'h612a, 32'h9, 32'h0, 1'b0, 32'h0, 1'b0);
		run(16'h3128, 32'h5, 32'h7, 1'b1, 32'hfffffffe, 1'b1);
		run(16'h312a, 32'h5, 32'h5, 1'b1, 32'hffffffff, 1'b1);
		run(16'h312a, 32'h7, 32'h5, 1'b1, 32'h1, 1'b0);
		run(16'h312b, 32'h80000000, 32'h1, 1'b0, 32'h7fffffff, 1'b1);
		run(16'h312b, 32'h5, 32'h1, 1'b1, 32'h4, 1'b0);
	endtask

	// Reset for ten cycles, then every scenario in turn.
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_rst();
		t_add();
		t_cmp();
		t_div();
		t_mul();
		t_acc();
		t_misc();
		end_sim();
	end
endmodule
